// ==== rtl/lamp_pkg.sv ====
// Package with register map, field layouts, timing counts and carrier types.
`default_nettype none
package lamp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CTRL_RI_EN_BIT = 0;
  localparam int unsigned CTRL_WL_EN_BIT = 1;
  localparam int unsigned CTRL_PING_BIT  = 2;
  localparam logic        CTRL_RI_EN_RST = 1'b0;
  localparam logic        CTRL_WL_EN_RST = 1'b0;

  localparam int unsigned STAT_LAMP_W    = 8;
  localparam int unsigned STAT_TEST_BIT  = 8;
  localparam int unsigned STAT_PING_BIT  = 9;
  localparam int unsigned STAT_SAFE_BIT  = 10;
  localparam int unsigned STAT_PAD_W     = 21;

  localparam int unsigned IRQ_N          = 4;
  localparam int unsigned IRQ_PING_DONE  = 0;
  localparam int unsigned IRQ_TEST_DONE  = 1;
  localparam int unsigned IRQ_CONTAM_ERR = 2;
  localparam int unsigned IRQ_PROTECT    = 3;
  localparam logic [IRQ_N-1:0] IRQ_RST   = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  localparam longint CLK_HZ        = 200_000_000;
  localparam longint TEST_TIME_MS  = 4000;
  localparam longint PING_TIME_MS  = 30000;
  localparam longint FLASH_HALF_MS = 250;
  localparam int unsigned CYC_W    = 33;
  localparam logic [CYC_W-1:0] TEST_CYC_DEF =
    CYC_W'(CLK_HZ * TEST_TIME_MS / 1000);
  localparam logic [CYC_W-1:0] PING_CYC_DEF =
    CYC_W'(CLK_HZ * PING_TIME_MS / 1000);
  localparam logic [CYC_W-1:0] FLASH_CYC_DEF =
    CYC_W'(CLK_HZ * FLASH_HALF_MS / 1000);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic protect;
    logic warn_a;
    logic warn_b;
  } field_set_type;

  typedef struct packed {
    logic eval_release;
    logic fault;
    logic ri_locked;
    logic peer_connected;
    logic contam_warn;
    logic contam_err;
  } sensor_status_type;

  typedef struct packed {
    logic l1_red;
    logic l1_green;
    logic l2_yellow;
    logic l3_blue;
    logic l4_blue;
    logic l4_green;
    logic l5_yellow;
    logic l5_green;
  } lamp_drive_type;

  localparam lamp_drive_type LAMPS_TEST = 8'hB5;

endpackage
`default_nettype wire

// ==== rtl/lamp_timer.sv ====
// Down-counting interval timer with busy level and done pulse.
`default_nettype none
module lamp_timer (
  // Clock and reset.
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  // Control.
  input  wire logic                       i_start,
  input  wire logic [lamp_pkg::CYC_W-1:0] i_count,
  // Status.
  output var  logic                       o_busy,
  output var  logic                       o_done
);
  import lamp_pkg::*;

  logic [CYC_W-1:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= '0;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else if (i_start) begin
      cnt_reg <= i_count;
      o_busy  <= (i_count != '0);
      o_done  <= 1'b0;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CYC_W'(1);
      o_busy  <= (cnt_reg != CYC_W'(1));
      o_done  <= (cnt_reg == CYC_W'(1));
    end else begin
      o_done  <= 1'b0;
    end
  end

endmodule // lamp_timer
`default_nettype wire

// ==== rtl/status_lamp_indicator.sv ====
// Front-panel status lamp driver with lamp test, locate timer and APB slave.
//
// Operation
// - Five lamps are driven separately, each with its own colour set.
// - A field set brings one protective and two warning occupancy flags.
// - One safety output pair is driven and selects the first lamp colour.
// - Second lamp dark if interlock disabled, or enabled and releasing.
// - Second lamp steady when blocked and ready, flashes if field occupied.
// - Third lamp off when neither warning field is occupied.
// - Third lamp steady when exactly one warning field is occupied.
// - Third lamp flashes when both warning fields are occupied.
// - Fourth lamp off, steady blue, or flashing blue with a connected peer.
// - A locate request flashes lamps four and five green for 30 seconds.
// - Fifth lamp off without contamination warning or error.
// - Contamination warning flashes fifth lamp yellow, outputs stay on.
// - Contamination error lights fifth lamp yellow, outputs switch off.
// - After power-up all five lamps light together for 4 seconds.
`default_nettype none
module status_lamp_indicator #(
  parameter logic [lamp_pkg::CYC_W-1:0] TEST_CYC  = lamp_pkg::TEST_CYC_DEF,
  parameter logic [lamp_pkg::CYC_W-1:0] PING_CYC  = lamp_pkg::PING_CYC_DEF,
  parameter logic [lamp_pkg::CYC_W-1:0] FLASH_CYC = lamp_pkg::FLASH_CYC_DEF
) (
  // Clock and reset.
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_b,
  // APB slave.
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [lamp_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [lamp_pkg::DATA_W-1:0] i_pwdata,
  output var  logic [lamp_pkg::DATA_W-1:0] o_prdata,
  output var  logic                        o_pready,
  output var  logic                        o_pslverr,
  // Sensor evaluation state.
  input  wire lamp_pkg::field_set_type     i_fields,
  input  wire lamp_pkg::sensor_status_type i_sensor,
  // Lamps, safety output pair and interrupt.
  output var  lamp_pkg::lamp_drive_type    o_lamps,
  output var  logic                        o_safety_output_pair,
  output var  logic                        o_irq
);
  import lamp_pkg::*;

  typedef enum logic [1:0] {
    ST_TEST = 2'b01,
    ST_RUN  = 2'b10
  } phase_type;

  phase_type        phase_reg;
  logic             kick_reg;
  logic             test_busy;
  logic             test_done;
  logic             ping_busy;
  logic             ping_done;
  logic             ping_start;
  logic [CYC_W-1:0] flash_cnt_reg;
  logic             flash_reg;
  logic             ri_en_reg;
  logic             wl_en_reg;
  logic [IRQ_N-1:0] irq_stat_reg;
  logic [IRQ_N-1:0] irq_mask_reg;
  logic [IRQ_N-1:0] irq_event;
  logic             contam_d_reg;
  logic             protect_d_reg;
  logic             setup;
  logic             wr_acc;
  logic             known;
  logic [DATA_W-1:0] rdata_next;
  lamp_drive_type   lamp_next;
  logic             safety_next;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Power-up lamp test phase.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      kick_reg  <= 1'b1;
      phase_reg <= ST_TEST;
    end else begin
      kick_reg <= 1'b0;
      case (phase_reg)
        ST_TEST: begin
          if (test_done) begin
            phase_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          phase_reg <= ST_RUN;
        end
        default: begin
          phase_reg <= ST_TEST;
        end
      endcase
    end
  end

  lamp_timer u_test_timer (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_start (kick_reg),
    .i_count (TEST_CYC),
    .o_busy  (test_busy),
    .o_done  (test_done)
  );

  lamp_timer u_ping_timer (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_start (ping_start),
    .i_count (PING_CYC),
    .o_busy  (ping_busy),
    .o_done  (ping_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flash rate divider.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flash_cnt_reg <= '0;
      flash_reg     <= 1'b0;
    end else if (flash_cnt_reg == '0) begin
      flash_cnt_reg <= FLASH_CYC - CYC_W'(1);
      flash_reg     <= ~flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg - CYC_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp and safety output decoding.
  always_comb begin
    lamp_next   = '0;
    safety_next = 1'b0;
    case (phase_reg)
      ST_TEST: begin
        lamp_next = LAMPS_TEST;
      end
      ST_RUN: begin
        safety_next = i_sensor.eval_release & ~i_sensor.contam_err;
        if (i_sensor.fault) begin
          lamp_next.l1_red = flash_reg;
        end else if (safety_next) begin
          lamp_next.l1_green = 1'b1;
        end else begin
          lamp_next.l1_red = 1'b1;
        end
        if (ri_en_reg) begin
          if (i_fields.protect) begin
            lamp_next.l2_yellow = flash_reg;
          end else begin
            lamp_next.l2_yellow = i_sensor.ri_locked;
          end
        end
        if (i_fields.warn_a & i_fields.warn_b) begin
          lamp_next.l3_blue = flash_reg;
        end else begin
          lamp_next.l3_blue = i_fields.warn_a | i_fields.warn_b;
        end
        if (ping_busy) begin
          lamp_next.l4_green = flash_reg;
          lamp_next.l5_green = flash_reg;
        end else begin
          if (wl_en_reg) begin
            lamp_next.l4_blue = i_sensor.peer_connected ? flash_reg
                                                        : 1'b1;
          end
          if (i_sensor.contam_err) begin
            lamp_next.l5_yellow = 1'b1;
          end else if (i_sensor.contam_warn) begin
            lamp_next.l5_yellow = flash_reg;
          end
        end
      end
      default: begin
        lamp_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lamps              <= '0;
      o_safety_output_pair <= 1'b0;
    end else begin
      o_lamps              <= lamp_next;
      o_safety_output_pair <= safety_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave with one wait-free access phase.
  assign setup  = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;
  assign known  = reg_hit(i_paddr, OFF_CTRL) | reg_hit(i_paddr, OFF_STATUS) |
                  reg_hit(i_paddr, OFF_IRQ_STAT) |
                  reg_hit(i_paddr, OFF_IRQ_MASK);
  assign ping_start = wr_acc & reg_hit(i_paddr, OFF_CTRL) &
                      i_pwdata[CTRL_PING_BIT];

  always_comb begin
    rdata_next = '0;
    if (reg_hit(i_paddr, OFF_CTRL)) begin
      rdata_next[CTRL_RI_EN_BIT] = ri_en_reg;
      rdata_next[CTRL_WL_EN_BIT] = wl_en_reg;
    end else if (reg_hit(i_paddr, OFF_STATUS)) begin
      rdata_next = {STAT_PAD_W'(0), o_safety_output_pair, ping_busy,
                    (phase_reg == ST_TEST), o_lamps};
    end else if (reg_hit(i_paddr, OFF_IRQ_STAT)) begin
      rdata_next[IRQ_N-1:0] = irq_stat_reg;
    end else if (reg_hit(i_paddr, OFF_IRQ_MASK)) begin
      rdata_next[IRQ_N-1:0] = irq_mask_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_pslverr <= ~known;
        o_prdata  <= i_pwrite ? '0 : rdata_next;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ri_en_reg    <= CTRL_RI_EN_RST;
      wl_en_reg    <= CTRL_WL_EN_RST;
      irq_mask_reg <= IRQ_RST;
    end else if (wr_acc) begin
      if (reg_hit(i_paddr, OFF_CTRL)) begin
        ri_en_reg <= i_pwdata[CTRL_RI_EN_BIT];
        wl_en_reg <= i_pwdata[CTRL_WL_EN_BIT];
      end
      if (reg_hit(i_paddr, OFF_IRQ_MASK)) begin
        irq_mask_reg <= i_pwdata[IRQ_N-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, write one to clear, set wins.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      contam_d_reg  <= 1'b0;
      protect_d_reg <= 1'b0;
      o_irq         <= 1'b0;
    end else begin
      contam_d_reg  <= i_sensor.contam_err;
      protect_d_reg <= i_fields.protect;
      o_irq         <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign irq_event[IRQ_PING_DONE]  = ping_done;
  assign irq_event[IRQ_TEST_DONE]  = test_done;
  assign irq_event[IRQ_CONTAM_ERR] = i_sensor.contam_err & ~contam_d_reg;
  assign irq_event[IRQ_PROTECT]    = i_fields.protect & ~protect_d_reg;

  for (genvar g = 0; g < IRQ_N; g++) begin : g_irq
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        irq_stat_reg[g] <= 1'b0;
      end else begin
        irq_stat_reg[g] <= irq_event[g] | (irq_stat_reg[g] &
          ~(wr_acc & reg_hit(i_paddr, OFF_IRQ_STAT) & i_pwdata[g]));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_test_lamps;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_TEST)
      |=> (o_lamps == LAMPS_TEST) && !o_safety_output_pair;
  endproperty
  a_test_lamps: assert property (p_test_lamps)
    else $error("Lamp test pattern wrong.");

  property p_test_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
      test_busy |-> (phase_reg == ST_TEST);
  endproperty
  a_test_hold: assert property (p_test_hold)
    else $error("Lamp test ended before its timer.");

  property p_err_off;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_sensor.contam_err |=> !o_safety_output_pair;
  endproperty
  a_err_off: assert property (p_err_off)
    else $error("Safety outputs on during contamination error.");

  property p_l5_err;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_RUN) && !ping_busy && i_sensor.contam_err
      |=> o_lamps.l5_yellow && !o_lamps.l5_green;
  endproperty
  a_l5_err: assert property (p_l5_err)
    else $error("Fifth lamp not steady yellow on error.");

  property p_l3_off;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_RUN) && !i_fields.warn_a && !i_fields.warn_b
      |=> !o_lamps.l3_blue;
  endproperty
  a_l3_off: assert property (p_l3_off)
    else $error("Third lamp lit with warning fields empty.");

  property p_l3_one;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_RUN) && (i_fields.warn_a ^ i_fields.warn_b)
      |=> o_lamps.l3_blue;
  endproperty
  a_l3_one: assert property (p_l3_one)
    else $error("Third lamp not steady with one warning field.");

  property p_l3_both;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_RUN) && i_fields.warn_a && i_fields.warn_b
      |=> o_lamps.l3_blue == $past(flash_reg);
  endproperty
  a_l3_both: assert property (p_l3_both)
    else $error("Third lamp not flashing with both warning fields.");

  property p_l2_off;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_RUN) && !ri_en_reg |=> !o_lamps.l2_yellow;
  endproperty
  a_l2_off: assert property (p_l2_off)
    else $error("Second lamp lit with interlock disabled.");

  property p_l2_flash;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_RUN) && ri_en_reg && i_fields.protect
      |=> o_lamps.l2_yellow == $past(flash_reg);
  endproperty
  a_l2_flash: assert property (p_l2_flash)
    else $error("Second lamp not flashing with protective field occupied.");

  property p_ping_len;
    @(posedge i_clk) disable iff (!i_rst_b)
      ping_start |=> ping_busy [*8];
  endproperty
  a_ping_len: assert property (p_ping_len)
    else $error("Locate timer ended early.");

  property p_l4_off;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_RUN) && !ping_busy && !wl_en_reg
      |=> !o_lamps.l4_blue && !o_lamps.l4_green;
  endproperty
  a_l4_off: assert property (p_l4_off)
    else $error("Fourth lamp lit with wireless link disabled.");

  property p_l1_green;
    @(posedge i_clk) disable iff (!i_rst_b)
      (phase_reg == ST_RUN) && !i_sensor.fault
      |=> o_lamps.l1_green == o_safety_output_pair;
  endproperty
  a_l1_green: assert property (p_l1_green)
    else $error("First lamp green does not follow safety outputs.");

endmodule // status_lamp_indicator
`default_nettype wire

// ==== testbench/lamp_panel_observer.sv ====
// Front-panel observer that records which lamps were seen lit and dark.
`default_nettype none
module lamp_panel_observer (
  // Clock and reset.
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  // Observation window control and lamps.
  input  wire logic                     i_clear,
  input  wire lamp_pkg::lamp_drive_type i_lamps,
  // Lamps seen lit and seen dark since the last clear.
  output var  logic [7:0]               o_seen_on,
  output var  logic [7:0]               o_seen_off
);
  timeunit 1ns;
  timeprecision 1ps;
  import lamp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Each lamp is watched alone, so a flashing lamp is seen lit and dark.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_seen_on  <= 8'h00;
      o_seen_off <= 8'h00;
    end else if (i_clear) begin
      o_seen_on  <= 8'h00;
      o_seen_off <= 8'h00;
    end else begin
      o_seen_on  <= o_seen_on | i_lamps;
      o_seen_off <= o_seen_off | ~i_lamps;
    end
  end
endmodule // lamp_panel_observer
`default_nettype wire

// ==== testbench/tb_status_lamp_indicator.sv ====
// Testbench for the status lamp driver with APB tasks and lamp cases.
`default_nettype none
module tb_status_lamp_indicator;
  timeunit 1ns;
  timeprecision 1ps;
  import lamp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [CYC_W-1:0] T_CYC = 33'h28;
  localparam logic [CYC_W-1:0] P_CYC = 33'h3C;
  localparam logic [CYC_W-1:0] F_CYC = 33'h4;

  logic              i_clk;
  logic              i_rst_b;
  logic              i_psel;
  logic              i_penable;
  logic              i_pwrite;
  logic [ADDR_W-1:0] i_paddr;
  logic [DATA_W-1:0] i_pwdata;
  logic [DATA_W-1:0] o_prdata;
  logic [DATA_W-1:0] rd;
  logic              o_pready;
  logic              o_pslverr;
  logic              err;
  logic              o_safety_output_pair;
  logic              o_irq;
  logic              obs_clear;
  field_set_type     i_fields;
  sensor_status_type i_sensor;
  lamp_drive_type    o_lamps;
  logic [7:0]        seen_on;
  logic [7:0]        seen_off;
  int                miscompares;
  int                samples_checked;

  status_lamp_indicator #(.TEST_CYC(T_CYC), .PING_CYC(P_CYC),
                          .FLASH_CYC(F_CYC)) DUT (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_fields(i_fields), .i_sensor(i_sensor),
    .o_lamps(o_lamps), .o_safety_output_pair(o_safety_output_pair),
    .o_irq(o_irq));

  lamp_panel_observer panel (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_clear(obs_clear),
    .i_lamps(o_lamps), .o_seen_on(seen_on), .o_seen_off(seen_off));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] wd);
    int n;
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    if (n == 16) begin
      check("pready wait", 32'h1, 32'h0);
      results();
    end else begin
      rd = o_prdata;
      err = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask

  task automatic observe(input logic [7:0] on_exp, input logic [7:0] off_exp);
    repeat (3) @(posedge i_clk);
    obs_clear <= 1'b1;
    @(posedge i_clk);
    obs_clear <= 1'b0;
    repeat (20) @(posedge i_clk);
    check("lamps lit", 32'(seen_on), 32'(on_exp));
    check("lamps dark", 32'(seen_off), 32'(off_exp));
  endtask

  task automatic run_case(input logic [2:0] ctrl, input logic [2:0] fld,
                          input logic [5:0] sen, input logic [7:0] on_exp,
                          input logic [7:0] off_exp, input logic safe);
    apb(1'b1, OFF_CTRL, {29'h0, ctrl});
    i_fields <= fld;
    i_sensor <= sen;
    observe(on_exp, off_exp);
    check("safety pair", 32'(o_safety_output_pair), 32'(safe));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    check("run length", 32'h1, 32'h0);
    results();
  end

  initial begin
    i_rst_b = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_fields = 3'h0;
    i_sensor = 6'h00;
    obs_clear = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (3) @(posedge i_clk);
    check("lamps in reset", 32'(o_lamps), 32'h0);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_clk);
    check("test pattern", 32'(o_lamps), 32'hB5);
    check("pair in test", 32'(o_safety_output_pair), 32'h0);
    repeat (25) @(posedge i_clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("test active", rd & 32'h100, 32'h100);
    repeat (12) @(posedge i_clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("test over", rd & 32'h100, 32'h0);
    check("lamps after test", 32'(o_lamps), 32'h80);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check("test done event", rd, 32'h2);
    $display("test power-up done");
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    check("mapped error", 32'(err), 32'h0);
    apb(1'b0, OFF_IRQ_MASK, 32'h0);
    check("mask reset", rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, OFF_IRQ_STAT, 32'h2);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check("event cleared", rd, 32'h0);
    $display("test registers done");
    run_case(3'h0, 3'h0, 6'h20, 8'h40, 8'hBF, 1'b1);
    run_case(3'h1, 3'h0, 6'h08, 8'hA0, 8'h5F, 1'b0);
    run_case(3'h1, 3'h4, 6'h08, 8'hA0, 8'h7F, 1'b0);
    run_case(3'h1, 3'h0, 6'h20, 8'h40, 8'hBF, 1'b1);
    run_case(3'h0, 3'h2, 6'h20, 8'h50, 8'hAF, 1'b1);
    run_case(3'h0, 3'h1, 6'h20, 8'h50, 8'hAF, 1'b1);
    run_case(3'h0, 3'h3, 6'h20, 8'h50, 8'hBF, 1'b1);
    run_case(3'h2, 3'h0, 6'h20, 8'h48, 8'hB7, 1'b1);
    run_case(3'h2, 3'h0, 6'h24, 8'h48, 8'hBF, 1'b1);
    run_case(3'h0, 3'h0, 6'h22, 8'h42, 8'hBF, 1'b1);
    run_case(3'h0, 3'h0, 6'h21, 8'h82, 8'h7D, 1'b0);
    run_case(3'h0, 3'h0, 6'h10, 8'h80, 8'hFF, 1'b0);
    $display("test lamp states done");
    apb(1'b1, OFF_IRQ_STAT, 32'hF);
    run_case(3'h4, 3'h0, 6'h20, 8'h45, 8'hBF, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("locate active", rd & 32'h200, 32'h200);
    repeat (20) @(posedge i_clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("locate still on", rd & 32'h200, 32'h200);
    repeat (20) @(posedge i_clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("locate over", rd & 32'h200, 32'h0);
    $display("test locate done");
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check("locate event", rd & 32'h1, 32'h1);
    check("masked irq", 32'(o_irq), 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    repeat (3) @(posedge i_clk);
    check("irq raised", 32'(o_irq), 32'h1);
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    repeat (3) @(posedge i_clk);
    check("irq cleared", 32'(o_irq), 32'h0);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check("event gone", rd & 32'h1, 32'h0);
    $display("test interrupt done");
    results();
  end
endmodule // tb_status_lamp_indicator
`default_nettype wire
